// ---- hw/ssfr_top.sv ----
// serial short-data framer, router and reassembler
`timescale 1ns/100ps
module ssfr_top #(
    parameter int IDLE_DEFAULT = ssfr_pkg::IDLE_CYCLES
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                reset,
    // configuration
    input  wire ssfr_pkg::ssfr_cfg_t cfg,
    input  wire logic                tblWrite,
    input  wire logic [10:0]         tblIndex,
    input  wire logic [23:0]         tblIdentity,
    // serial bytes from terminal side
    input  wire logic                serInValid,
    input  wire ssfr_pkg::ssfr_ser_t serIn,
    output logic                     serInReady,
    // messages to radio
    output logic                     radioTxValid,
    output ssfr_pkg::ssfr_msg_t      radioTx,
    input  wire logic                radioTxReady,
    // messages from radio
    input  wire logic                radioRxValid,
    input  wire ssfr_pkg::ssfr_msg_t radioRx,
    output logic                     radioRxReady,
    // serial bytes to terminal side
    output logic                     serOutValid,
    output ssfr_pkg::ssfr_ser_t      serOut,
    input  wire logic                serOutReady,
    // status
    output logic [23:0]              lastSender,
    output logic                     rxDropped
);
    import ssfr_pkg::*;
    //--------------------------------------------------
    // transmit state
    //--------------------------------------------------
    typedef enum {S_COLLECT, S_FLUSH, S_LOOKUP, S_ROUTE,
                  S_SEND} ssfr_tx_t;
    ssfr_tx_t    txState_r, txState_nxt;
    logic [7:0]  txMem [MEM_DEPTH];   // coded block
    logic [23:0] table_r [TABLE_DEPTH]; // routing table
    logic [11:0] wp_r;                // write pointer
    logic [11:0] rp_r;                // read pointer
    logic [9:0]  rawCnt_r;            // raw bytes taken
    logic [21:0] idleCnt_r;           // quiet cycles
    logic [15:0] addr_r;              // extracted address
    logic        blkSec_r;            // source port
    logic [7:0]  chk_r;               // running xor
    logic [7:0]  runByte_r, runLen_r; // pending run
    logic        runHave_r;
    logic [23:0] tblQ_r, destId_r;
    logic        routeOk_r;
    logic [7:0]  fragCnt_r;           // bytes in message
    logic [9:0]  fragIdx_r;
    logic        inReady_r;
    logic        take, idleHit, pushV, bufReady;
    logic [21:0] idleLimit;
    logic [7:0]  effCeil;
    logic [15:0] tblIdx;
    ssfr_msg_t   pushW;
    logic [7:0]  wrB [4];             // bytes written now
    logic [2:0]  wrN;
    logic [7:0]  xorNow;

    assign take      = serInValid && inReady_r;
    // zero idle setting falls back to the default
    assign idleLimit = (cfg.idleCycles != 22'h0) ? cfg.idleCycles
                                                 : 22'(IDLE_DEFAULT);
    assign effCeil   = (cfg.msgCeil > 8'(MSG_MAX_BYTES))
                       ? 8'(MSG_MAX_BYTES)
                       : ((cfg.msgCeil == 8'h0) ? 8'h1 : cfg.msgCeil);
    // ascending addresses from the first one
    assign tblIdx    = addr_r - cfg.firstAddr;
    // quiet line for the interval closes the block
    assign idleHit   = (txState_r == S_COLLECT) && (rawCnt_r != 10'h0)
                       && !take && (idleCnt_r >= idleLimit - 22'h1);

    // run coder: escape triple for long runs and escapes
    function automatic logic [26:0] ssfrRun(input logic [7:0] b,
                                            input logic [7:0] n);
        if (n >= RUN_MIN || b == ESC_BYTE)
            return {3'h3, ESC_BYTE, n, b};
        return {n[2:0], b, b, 8'h00};
    endfunction

    //--------------------------------------------------
    // bytes written this cycle
    //--------------------------------------------------
    always_comb begin
        logic [26:0] runF;
        logic        flush, raw;
        runF   = ssfrRun(runByte_r, runLen_r);
        wrB    = '{default: 8'h00};
        wrN    = 3'h0;
        xorNow = chk_r;
        flush  = 1'b0;
        raw    = 1'b0;
        // bytes past the block limit are lost
        if (take && rawCnt_r != 10'(BLOCK_MAX)) begin
            if (!cfg.compressEn)
                raw = 1'b1;
            else if (!(runHave_r && serIn.data == runByte_r
                       && runLen_r != RUN_MAX))
                flush = runHave_r;
        end
        if (txState_r == S_FLUSH)
            flush = runHave_r;
        // finished runs leave as coded bytes
        if (flush) begin
            wrB[0] = runF[23:16];
            wrB[1] = runF[15:8];
            wrB[2] = runF[7:0];
            wrN    = runF[26:24];
        end
        // plain bytes when compression is off
        if (raw) begin
            wrB[wrN[1:0]] = serIn.data;
            wrN = wrN + 3'h1;
        end
        for (int k = 0; k < 3; k++)
            if (3'(k) < wrN)
                xorNow = xorNow ^ wrB[k];
        // checksum byte closes the block
        if (txState_r == S_FLUSH) begin
            wrB[wrN[1:0]] = xorNow;
            wrN = wrN + 3'h1;
        end
    end

    //--------------------------------------------------
    // coded block memory
    //--------------------------------------------------
    always_ff @(posedge clock) begin
        for (int k = 0; k < 4; k++)
            if (3'(k) < wrN)
                txMem[wp_r + 12'(k)] <= wrB[k];
    end

    // routing table written from configuration side
    always_ff @(posedge clock) begin
        if (tblWrite && tblIndex < 11'(TABLE_DEPTH))
            table_r[tblIndex] <= tblIdentity;
    end

    //--------------------------------------------------
    // transmit sequence
    //--------------------------------------------------
    always_comb begin
        txState_nxt = txState_r;
        case (txState_r)
            S_COLLECT: if (idleHit) txState_nxt = S_FLUSH;
            S_FLUSH:   txState_nxt = S_LOOKUP;
            S_LOOKUP:  txState_nxt = S_ROUTE;
            // unroutable block is dropped
            S_ROUTE:   txState_nxt = routeOk_r ? S_SEND : S_COLLECT;
            S_SEND:    if (bufReady && rp_r == wp_r - 12'h1)
                           txState_nxt = S_COLLECT;
            default:   txState_nxt = S_COLLECT;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            txState_r <= S_COLLECT;
            inReady_r <= 1'b0;
        end else begin
            txState_r <= txState_nxt;
            inReady_r <= (txState_nxt == S_COLLECT);
        end
    end
    assign serInReady = inReady_r;

    // collection: pointers, run, address, idle count
    always_ff @(posedge clock) begin
        if (reset || (txState_r == S_ROUTE && !routeOk_r)) begin
            wp_r <= 12'h0;
            rawCnt_r <= 10'h0;
            idleCnt_r <= 22'h0;
            chk_r <= 8'h00;
            runHave_r <= 1'b0;
            runByte_r <= 8'h00;
            runLen_r <= 8'h00;
            addr_r <= 16'h0;
            blkSec_r <= 1'b0;
        end else if (txState_r == S_SEND && txState_nxt == S_COLLECT) begin
            wp_r <= 12'h0;
            rawCnt_r <= 10'h0;
            chk_r <= 8'h00;
        end else begin
            wp_r <= wp_r + 12'(wrN);
            chk_r <= (txState_r == S_FLUSH) ? 8'h00 : xorNow;
            // every new byte restarts the quiet count
            idleCnt_r <= take ? 22'h0 : idleCnt_r + 22'h1;
            if (txState_r == S_FLUSH)
                runHave_r <= 1'b0;
            if (take && rawCnt_r != 10'(BLOCK_MAX)) begin
                rawCnt_r <= rawCnt_r + 10'h1;
                if (rawCnt_r == 10'h0)
                    blkSec_r <= serIn.secPort;
                // address at programmed offset, one or two bytes
                if (rawCnt_r == cfg.addrPos)
                    addr_r <= cfg.addrTwo ? {serIn.data, 8'h00}
                                          : {8'h00, serIn.data};
                if (cfg.addrTwo && rawCnt_r == cfg.addrPos + 10'h1)
                    addr_r[7:0] <= serIn.data;
                if (cfg.compressEn) begin
                    if (runHave_r && serIn.data == runByte_r
                        && runLen_r != RUN_MAX) begin
                        runLen_r <= runLen_r + 8'h1;
                    end else begin
                        runByte_r <= serIn.data;
                        runLen_r <= 8'h01;
                        runHave_r <= 1'b1;
                    end
                end
            end
        end
    end

    // lookup and destination choice
    always_ff @(posedge clock) begin
        if (reset) begin
            tblQ_r <= 24'h0;
            destId_r <= 24'h0;
            routeOk_r <= 1'b0;
        end else if (txState_r == S_LOOKUP) begin
            // identity read for the extracted address
            tblQ_r <= table_r[tblIdx[10:0]];
            routeOk_r <= cfg.fixedDest || cfg.slaveMode
                         || tblIdx < 16'(TABLE_DEPTH);
        end else if (txState_r == S_ROUTE) begin
            // fixed identity wins in both roles
            if (cfg.fixedDest)
                destId_r <= cfg.fixedId;
            // reply to the most recent master
            else if (cfg.slaveMode)
                destId_r <= lastSender;
            // table entry may hold a group identity
            else
                destId_r <= tblQ_r;
        end
    end

    //--------------------------------------------------
    // fragmentation
    //--------------------------------------------------
    assign pushV = (txState_r == S_SEND);
    always_comb begin
        pushW.peerId = destId_r;
        pushW.dstSec = blkSec_r ? !cfg.secToPri : cfg.priToSec;
        pushW.compressed = cfg.compressEn;
        pushW.fragIdx = fragIdx_r;
        pushW.lastFrag = (rp_r == wp_r - 12'h1);
        // cut at ceiling over the coded block
        pushW.endMsg = pushW.lastFrag || fragCnt_r == effCeil - 8'h1;
        pushW.data = txMem[rp_r];
    end

    always_ff @(posedge clock) begin
        if (reset || txState_r != S_SEND) begin
            rp_r <= 12'h0;
            fragCnt_r <= 8'h00;
            fragIdx_r <= 10'h0;
        end else if (bufReady) begin
            rp_r <= rp_r + 12'h1;
            fragCnt_r <= pushW.endMsg ? 8'h00 : fragCnt_r + 8'h1;
            if (pushW.endMsg)
                fragIdx_r <= fragIdx_r + 10'h1;
        end
    end

    // two-entry buffer toward the radio; head is the output
    logic      v0_r, v1_r;
    ssfr_msg_t s1_r;
    logic      pop;
    assign bufReady = !v1_r;
    assign pop      = v0_r && radioTxReady;
    always_ff @(posedge clock) begin
        if (reset) begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
            radioTx <= '0;
            s1_r <= '0;
        end else if (pop) begin
            if (v1_r) begin
                radioTx <= s1_r;
                // full buffer took no push this cycle
                v1_r <= 1'b0;
            end else begin
                radioTx <= pushW;
                v0_r <= pushV;
            end
        end else if (pushV && !v1_r) begin
            if (!v0_r) begin
                radioTx <= pushW;
                v0_r <= 1'b1;
            end else begin
                s1_r <= pushW;
                v1_r <= 1'b1;
            end
        end
    end
    assign radioTxValid = v0_r;

    //--------------------------------------------------
    // receive: reassembly, check, delivery
    //--------------------------------------------------
    logic [7:0]  rxMem [MEM_DEPTH];
    logic [11:0] rwp_r, orp_r;
    logic [9:0]  expIdx_r;
    logic        bad_r, inMsg_r, rxOut_r, rxComp_r, rxSec_r;
    logic [7:0]  rxChk_r, repByte_r, repLeft_r;
    logic        rxTake, rxDone, chkOk;
    logic [23:0] rxSrc_r;
    assign rxTake = radioRxValid && radioRxReady;
    assign rxDone = rxTake && radioRx.endMsg && radioRx.lastFrag;
    // xor over data and checksum byte comes to zero
    assign chkOk  = (rxChk_r ^ radioRx.data) == 8'h00;

    always_ff @(posedge clock) begin
        // fragment zero of a new block lands at the start
        if (rxTake && !inMsg_r && radioRx.fragIdx == 10'h0)
            rxMem[0] <= radioRx.data;
        else if (rxTake)
            rxMem[rwp_r] <= radioRx.data;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rwp_r <= 12'h0;
            expIdx_r <= 10'h0;
            bad_r <= 1'b0;
            inMsg_r <= 1'b0;
            rxChk_r <= 8'h00;
            rxOut_r <= 1'b0;
            rxDropped <= 1'b0;
            lastSender <= 24'h0;
            rxComp_r <= 1'b0;
            rxSec_r <= 1'b0;
            rxSrc_r <= 24'h0;
        end else begin
            rxDropped <= 1'b0;
            if (rxDone) begin
                // only a whole, clean block goes out
                if (!bad_r && chkOk
                    && radioRx.fragIdx == expIdx_r) begin
                    rxOut_r <= 1'b1;
                    lastSender <= radioRx.peerId;
                    rxComp_r <= radioRx.compressed;
                    rxSec_r <= radioRx.dstSec || (cfg.auxSrcEn
                               && radioRx.peerId == cfg.auxSrcId);
                end else begin
                    rwp_r <= 12'h0;
                    rxDropped <= 1'b1;
                end
                expIdx_r <= 10'h0;
                bad_r <= 1'b0;
                inMsg_r <= 1'b0;
                rxChk_r <= 8'h00;
            end else if (rxTake) begin
                // fragment zero restarts; gaps spoil it
                if (!inMsg_r && radioRx.fragIdx == 10'h0) begin
                    rwp_r <= 12'h1;
                    bad_r <= 1'b0;
                    rxSrc_r <= radioRx.peerId;
                    rxChk_r <= radioRx.data;
                end else begin
                    rwp_r <= rwp_r + 12'h1;
                    rxChk_r <= rxChk_r ^ radioRx.data;
                    if (radioRx.fragIdx != expIdx_r
                        || radioRx.peerId != rxSrc_r)
                        bad_r <= 1'b1;
                end
                inMsg_r <= !radioRx.endMsg;
                if (radioRx.endMsg)
                    expIdx_r <= radioRx.fragIdx + 10'h1;
            end else if (rxOut_r && orp_r >= rwp_r
                         && repLeft_r == 8'h00
                         && (!serOutValid || serOutReady)) begin
                rxOut_r <= 1'b0;
                rwp_r <= 12'h0;
            end
        end
    end

    // delivery holds off new messages until done
    always_ff @(posedge clock) begin
        if (reset)
            radioRxReady <= 1'b0;
        else
            radioRxReady <= !rxOut_r && !rxDone;
    end

    // expansion of runs on the way out
    always_ff @(posedge clock) begin
        if (reset || !rxOut_r) begin
            orp_r <= 12'h0;
            repLeft_r <= 8'h00;
            repByte_r <= 8'h00;
            serOutValid <= 1'b0;
            serOut <= '0;
        end else if (!serOutValid || serOutReady) begin
            serOut.secPort <= rxSec_r;
            serOutValid <= 1'b1;
            if (repLeft_r != 8'h00) begin
                serOut.data <= repByte_r;
                repLeft_r <= repLeft_r - 8'h1;
            end else if (orp_r < rwp_r) begin
                if (rxComp_r && rxMem[orp_r] == ESC_BYTE) begin
                    serOut.data <= rxMem[orp_r + 12'h2];
                    repByte_r <= rxMem[orp_r + 12'h2];
                    repLeft_r <= rxMem[orp_r + 12'h1] - 8'h1;
                    orp_r <= orp_r + 12'h3;
                end else begin
                    serOut.data <= rxMem[orp_r];
                    orp_r <= orp_r + 12'h1;
                end
            end else begin
                serOutValid <= 1'b0;
            end
        end
    end

    //--------------------------------------------------
    // checks
    //--------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [8:0] outCnt_r;  // bytes of the message on the radio
    always_ff @(posedge clock) begin
        if (reset)
            outCnt_r <= 9'h0;
        else if (pop)
            outCnt_r <= radioTx.endMsg ? 9'h0 : outCnt_r + 9'h1;
    end
    msg_ceiling_a: assert property (outCnt_r < 9'(MSG_MAX_BYTES))
        else $error("message longer than allowed");
    frag_last_a: assert property (v0_r && radioTx.lastFrag
        |-> radioTx.endMsg) else $error("last fragment not at end");
    chk_drop_a: assert property (rxDone && !chkOk
        |=> !rxOut_r && rxDropped) else $error("bad block delivered");
    table_dest_a: assert property (txState_r == S_ROUTE
        && !cfg.fixedDest && !cfg.slaveMode && routeOk_r
        |=> destId_r == $past(tblQ_r)) else $error("wrong table id");
    idle_end_a: assert property (take ##1 !serInValid [*2]
        |-> idleCnt_r == 22'h1) else $error("idle count off");
    slave_dest_a: assert property (txState_r == S_ROUTE
        && cfg.slaveMode && !cfg.fixedDest
        |=> destId_r == $past(lastSender)) else $error("reply id");
    fixed_dest_a: assert property (txState_r == S_ROUTE
        && cfg.fixedDest |=> destId_r == $past(cfg.fixedId))
        else $error("fixed id ignored");
    slave_record_a: assert property (rxDone && !bad_r && chkOk
        && radioRx.fragIdx == expIdx_r
        |=> lastSender == $past(radioRx.peerId))
        else $error("sender not recorded");
    frag_gap_a: assert property (rxTake && inMsg_r && !rxDone
        && radioRx.fragIdx != expIdx_r |=> bad_r)
        else $error("gap not caught");
endmodule

// ---- inc/ssfr_pkg.sv ----
// constants and types of the serial short-data framer and router
// Function
// - messages carry at most 254 bytes, user ceiling
// - long blocks split, receiver rejoins them
// - checksum mismatch drops the whole block
// - table of 1280 identities, ascending addresses
// - address position and width programmable
// - idle interval ends a serial block
// - master looks up identity, sends block
// - broadcast address maps to group identity
// - optional fixed destination identity
// - slave outputs records, records sender
// - slave replies to latest sender
// - fixed master identity overrides latest sender
// - each port has its own destination port
// - crossed port delivers to opposite port
// - optional run-length compression, receiver expands
// - compression can be switched off
// - serial blocks up to 1000 bytes
// - configured ceiling above 254 is clamped to 254
// - one sender identity goes to secondary
package ssfr_pkg;
    //--------------------------------------------------
    // timing
    //--------------------------------------------------
    localparam int CLK_MHZ     = 200;
    localparam int IDLE_MS     = 10;
    localparam int IDLE_CYCLES = IDLE_MS * 1000 * CLK_MHZ;
    //--------------------------------------------------
    // sizes
    //--------------------------------------------------
    localparam int MSG_MAX_BITS  = 2047;
    localparam int MSG_MAX_BYTES = 254;
    localparam int CEIL_MAX      = 255;
    localparam int BLOCK_MAX     = 1000;
    localparam int TABLE_DEPTH   = 1280;
    localparam int MEM_DEPTH     = 4096;
    // run coding: escape, length, byte
    localparam logic [7:0] ESC_BYTE = 8'hF5;
    localparam logic [7:0] RUN_MIN  = 8'h03;
    localparam logic [7:0] RUN_MAX  = 8'hFF;
    //--------------------------------------------------
    // carriers
    //--------------------------------------------------
    typedef struct packed {
        logic        slaveMode;  // slave role
        logic        fixedDest;  // fixed identity
        logic [23:0] fixedId;    // fixed identity value
        logic [9:0]  addrPos;    // address byte offset
        logic        addrTwo;    // two-byte address
        logic [15:0] firstAddr;  // address of entry 0
        logic [7:0]  msgCeil;    // bytes per message
        logic        compressEn; // compression on
        logic        priToSec;   // primary -> secondary
        logic        secToPri;   // secondary -> primary
        logic        auxSrcEn;   // sender steering on
        logic [23:0] auxSrcId;   // steered sender
        logic [21:0] idleCycles; // 0: default
    } ssfr_cfg_t;
    typedef struct packed {
        logic       secPort;     // secondary port
        logic [7:0] data;
    } ssfr_ser_t;
    typedef struct packed {
        logic [23:0] peerId;     // dest or source
        logic        dstSec;     // remote port
        logic        compressed; // payload coded
        logic [9:0]  fragIdx;    // fragment number
        logic        lastFrag;   // final fragment
        logic        endMsg;     // final message byte
        logic [7:0]  data;
    } ssfr_msg_t;
endpackage

// ---- sim/ssfr_term_model.sv ----
// terminal-side model that takes serial bytes with periodic stalls
`timescale 1ns/100ps
module ssfr_term_model (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                reset,
    // serial bytes from the block
    input  wire logic                serOutValid,
    input  wire ssfr_pkg::ssfr_ser_t serOut,
    output logic                     serOutReady
);
    import ssfr_pkg::*;
    ssfr_ser_t  got[$];   // bytes taken, with their port
    logic [1:0] stall_r;  // stall phase
    // one stall in four checks that no byte is lost
    always @(posedge clock) begin
        if (reset) begin
            stall_r <= 2'h0;
        end else begin
            stall_r <= stall_r + 2'h1;
        end
        if (!reset && serOutValid && serOutReady) begin
            got.push_back(serOut);
        end
    end
    assign serOutReady = (stall_r != 2'h3);
endmodule

// ---- sim/tb_ssfr_top.sv ----
// self-checking bench of the serial framer and router
`timescale 1ns/100ps
`define CMP(n,e,g) begin checksDone++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
  mismatches++; end end
module tb_ssfr_top;
    import ssfr_pkg::*;
    typedef struct {
        logic [7:0]  addr;
        logic        sp, p2s, fx, cp;
        int          c;
        logic [23:0] id;
        logic        ds;
    } ssfr_row_t;
    logic        clock = 0, reset = 1, tblWrite = 0;
    ssfr_cfg_t   cfg = '0;
    logic [10:0] tblIndex = '0;
    logic [23:0] tblIdentity = '0, lastSender;
    logic        serInValid = 0, serInReady, radioTxReady = 1;
    ssfr_ser_t   serIn = '0, serOut;
    logic        radioTxValid, radioRxValid = 0, radioRxReady;
    ssfr_msg_t   radioTx, radioRx = '0;
    logic        serOutValid, serOutReady, rxDropped;
    logic [7:0]  src[$], blk[$];
    int          mismatches = 0, checksDone = 0, n;
    // address, port, fixed and split cases
    ssfr_row_t   rows[6] = '{
        '{8'h05, 0, 0, 0, 0, 254, 24'h00A100, 0},
        '{8'h07, 0, 0, 0, 0, 2, 24'h00A102, 0},
        '{8'h06, 1, 0, 0, 0, 254, 24'h00A101, 1},
        '{8'h06, 0, 1, 0, 0, 254, 24'h00A101, 1},
        '{8'h05, 0, 0, 1, 0, 254, 24'h00F00D, 0},
        '{8'h05, 0, 0, 0, 1, 3, 24'h00A100, 0}};
    ssfr_top #(.IDLE_DEFAULT(20)) i_ssfr_top (.clock, .reset, .cfg,
        .tblWrite, .tblIndex, .tblIdentity, .serInValid, .serIn,
        .serInReady, .radioTxValid, .radioTx, .radioTxReady,
        .radioRxValid, .radioRx, .radioRxReady, .serOutValid, .serOut,
        .serOutReady, .lastSender, .rxDropped);
    ssfr_term_model i_ssfr_term_model (.clock, .reset, .serOutValid,
        .serOut, .serOutReady);
    initial forever #2.5 clock = ~clock;
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // bounded wait for a ready output, rx selects which
    task automatic waitRdy(input logic rx);
        for (int k = 0; k < 500; k++) begin
            if ((rx ? radioRxReady : serInReady) === 1'b1) return;
            @(negedge clock);
        end
        mismatches++;
        wrapUp();
    endtask
    // expected coded block: plain bytes then xor check byte
    task automatic mkBlk();
        logic [7:0] x;
        x = 8'h00;
        blk = src;
        foreach (src[j]) x ^= src[j];
        blk.push_back(x);
    endtask
    // bytes go back to back, no pause inside a block
    task automatic putSer(input logic sp);
        foreach (src[j]) begin
            waitRdy(0);
            serIn = '{sp, src[j]};
            serInValid = 1;
            @(negedge clock);
        end
        serInValid = 0;
        mkBlk();
    endtask
    task automatic getTx(input logic [23:0] id, input logic ds, cp,
                         input int c);
        int   i;
        logic e;
        i = 0;
        for (int k = 0; k < 300 && i < blk.size(); k++) begin
            @(negedge clock);
            radioTxReady = k[0];
            if (radioTxValid && radioTxReady) begin
                e = (i % c == c - 1) || (i == blk.size() - 1);
                `CMP("data", blk[i], radioTx.data)
                `CMP("peer", id, radioTx.peerId)
                `CMP("port", ds, radioTx.dstSec)
                `CMP("coded", cp, radioTx.compressed)
                `CMP("frag", 10'(i / c), radioTx.fragIdx)
                `CMP("end", e, radioTx.endMsg)
                `CMP("last", i == blk.size() - 1, radioTx.lastFrag)
                i++;
            end
        end
        radioTxReady = 1;
        `CMP("beats", blk.size(), i)
        if (i < blk.size()) wrapUp();
    endtask
    task automatic putRx(input logic [23:0] id, input int g);
        foreach (blk[j]) begin
            waitRdy(1);
            radioRx = '{id, 1'b0, 1'b0, 10'(j > 0 ? g : 0),
                        j == blk.size() - 1,
                        j == blk.size() - 1, blk[j]};
            radioRxValid = 1;
            @(negedge clock);
        end
        radioRxValid = 0;
    endtask
    initial begin
        repeat (3) @(negedge clock);
        reset = 0;
        @(negedge clock);
        cfg.addrPos = 10'h001;
        cfg.firstAddr = 16'h0005;
        cfg.fixedId = 24'h00F00D;
        // entries loaded in ascending address order
        for (int t = 0; t < 3; t++) begin
            tblWrite = 1;
            tblIndex = 11'(t);
            tblIdentity = 24'h00A100 + 24'(t);
            @(negedge clock);
        end
        tblWrite = 0;
        foreach (rows[r]) begin
            cfg.priToSec = rows[r].p2s;
            cfg.fixedDest = rows[r].fx;
            cfg.compressEn = rows[r].cp;
            cfg.msgCeil = 8'(rows[r].c);
            src = '{8'h11, rows[r].addr, 8'h22, 8'h33};
            putSer(rows[r].sp);
            getTx(rows[r].id, rows[r].ds, rows[r].cp, rows[r].c);
            $display("row %0d done", r);
        end
        // two-byte address, longer idle setting
        cfg.addrTwo = 1;
        cfg.idleCycles = 22'h28;
        src = '{8'h11, 8'h00, 8'h06, 8'h33};
        putSer(0);
        getTx(24'h00A101, 0, 1, 3);
        cfg.addrTwo = 0;
        // good block from a steered sender
        cfg.auxSrcEn = 1;
        cfg.auxSrcId = 24'h00BEEF;
        src = '{8'hA1, 8'hB2};
        mkBlk();
        putRx(24'h00BEEF, 0);
        repeat (20) @(negedge clock);
        n = i_ssfr_term_model.got.size();
        `CMP("outCnt", 2, n)
        `CMP("out0", 9'h1A1, i_ssfr_term_model.got[0])
        `CMP("out1", 9'h1B2, i_ssfr_term_model.got[1])
        `CMP("sender", 24'h00BEEF, lastSender)
        // corrupted check byte, new source must not stick
        blk[blk.size() - 1] ^= 8'h01;
        putRx(24'h00C0DE, 0);
        n = 0;
        for (int k = 0; k < 10; k++) begin
            n += rxDropped;
            @(negedge clock);
        end
        `CMP("drops", 1, n)
        `CMP("noOut", 2, i_ssfr_term_model.got.size())
        `CMP("keepSnd", 24'h00BEEF, lastSender)
        // fragment gap inside a good block drops it
        blk[blk.size() - 1] ^= 8'h01;
        putRx(24'h00C0DE, 1);
        repeat (10) @(negedge clock);
        `CMP("gapOut", 2, i_ssfr_term_model.got.size())
        `CMP("gapSnd", 24'h00BEEF, lastSender)
        $display("receive test done");
        // slave replies: latest master, then fixed identity
        cfg.slaveMode = 1;
        cfg.fixedDest = 0;
        cfg.compressEn = 0;
        cfg.msgCeil = 8'hFE;
        src = '{8'h55, 8'h66};
        putSer(0);
        getTx(24'h00BEEF, 0, 0, 254);
        cfg.fixedDest = 1;
        putSer(0);
        getTx(24'h00F00D, 0, 0, 254);
        $display("slave test done");
        reset = 1;
        repeat (3) @(negedge clock);
        `CMP("rstIn", 1'b0, serInReady)
        `CMP("rstRx", 1'b0, radioRxReady)
        `CMP("rstTx", 1'b0, radioTxValid)
        reset = 0;
        @(negedge clock);
        `CMP("relIn", 1'b1, serInReady)
        $display("reset test done");
        wrapUp();
    end
endmodule
